/* logic/ppm_regs.sv */
// Power management capability and control/status registers of a port
`timescale 1ns/1ps
module ppm_regs
  import ppm_pkg::*;
#(
  parameter bit UPSTREAM = 1'b0
)
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic hot_rst_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic own_wake_i,
  input wire logic fwd_wake_i,
  output logic wake_msg_o,
  output logic fwd_msg_o,
  output logic ctx_reset_o,
  output logic [1:0] power_state_o,
  output logic irq_o
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire logic acc = psel_i & penable_i & ~pready_o;
  wire logic wr = acc & pwrite_i;
  wire logic rd = acc & ~pwrite_i;
  wire logic sel_cap = paddr_i == PPM_CAP_OFFS;
  wire logic sel_csr = paddr_i == PPM_CSR_OFFS;
  wire logic sel_ist = paddr_i == PPM_IRQ_STAT_OFFS;
  wire logic sel_imk = paddr_i == PPM_IRQ_MASK_OFFS;
  wire logic sel_ctl = paddr_i == PPM_CTRL_OFFS;
  wire logic mapped = sel_cap | sel_csr | sel_ist | sel_imk | sel_ctl;
  ppm_wr_t cw;
  assign cw.wr = wr & sel_csr;
  assign cw.wdata = pwdata_i;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic dev_specific_init_flag_q;
  logic [4:0] pmesup_q;
  logic [1:0] power_state_field_q;
  logic keep_q;
  logic wen_q;
  logic wst_q;
  logic lock_q;
  logic d3cold_q;
  logic [PPM_IRQ_W-1:0] ist_q;
  logic [PPM_IRQ_W-1:0] imk_q;

  // Writes to the capability word pass only while unlocked
  wire logic cap_wr = wr & sel_cap & ~lock_q;
  wire logic [1:0] ps_wdata = cw.wdata[PPM_POWER_STATE_FIELD_LSB+1:PPM_POWER_STATE_FIELD_LSB];
  wire logic ps_ok = (ps_wdata == PPM_D0) | (ps_wdata == PPM_D3HOT);
  wire logic ps_wr = cw.wr & ps_ok;
  wire logic ps_bad = cw.wr & ~ps_ok;
  wire logic wake_to_d0 = ps_wr & (power_state_field_q == PPM_D3HOT) & (ps_wdata == PPM_D0);
  wire logic ctx_rst = wake_to_d0 & ~keep_q;
  // Wake generation uses the fixed reset pattern, never the written copy
  wire logic gen_allowed = PPM_PMESUP_RST[4] | PPM_PMESUP_RST[3];
  wire logic own_ev = own_wake_i & ~UPSTREAM & gen_allowed;
  wire logic wst_set = own_ev;
  wire logic wst_clr = cw.wr & cw.wdata[PPM_WST_BIT];

  // Capability fields, hot reset restores the non-sticky defaults
  always_ff @(posedge clock_i)
  begin
    if (srst_i | hot_rst_i)
    begin
      dev_specific_init_flag_q <= PPM_DEV_SPECIFIC_INIT_FLAG_RST;
      pmesup_q <= PPM_PMESUP_RST;
    end
    else if (cap_wr)
    begin
      dev_specific_init_flag_q <= pwdata_i[PPM_DEV_SPECIFIC_INIT_FLAG_BIT];
      pmesup_q <= pwdata_i[PPM_PMESUP_LSB+4:PPM_PMESUP_LSB];
    end
  end

  // Power state and keep-context flag; a context reset returns to defaults
  always_ff @(posedge clock_i)
  begin
    if (srst_i | hot_rst_i | ctx_rst)
    begin
      power_state_field_q <= PPM_POWER_STATE_FIELD_RST;
      keep_q <= PPM_KEEP_RST;
    end
    else if (cw.wr)
    begin
      if (ps_ok)
        power_state_field_q <= ps_wdata;
      if (!lock_q)
        keep_q <= cw.wdata[PPM_KEEP_BIT];
    end
  end

  // Sticky bits: only the full reset touches them
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      wen_q <= PPM_WEN_RST;
      wst_q <= 1'b0;
    end
    else
    begin
      if (cw.wr)
        wen_q <= cw.wdata[PPM_WEN_BIT];
      wst_q <= wst_set | (wst_q & ~wst_clr);
    end
  end

  // Own control: write lock and D3cold indication
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      lock_q <= 1'b0;
      d3cold_q <= 1'b0;
    end
    else if (wr & sel_ctl)
    begin
      lock_q <= pwdata_i[PPM_CTRL_LOCK_BIT];
      d3cold_q <= pwdata_i[PPM_CTRL_D3C_BIT];
    end
  end

  // ------------------------------------------------------------
  // Interrupt status, mask and output
  // ------------------------------------------------------------
  wire logic [PPM_IRQ_W-1:0] ev = {ps_bad, ctx_rst, own_ev};
  wire logic ist_rd = rd & sel_ist;
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ist_q <= '0;
      imk_q <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      ist_q <= ev | (ist_rd ? '0 : ist_q);
      if (wr & sel_imk)
        imk_q <= pwdata_i[PPM_IRQ_W-1:0];
      irq_o <= |(ist_q & imk_q);
    end
  end

  // ------------------------------------------------------------
  // Read data assembly
  // ------------------------------------------------------------
  logic [31:0] cap_word;
  logic [31:0] csr_word;
  always_comb
  begin
    cap_word = '0;
    cap_word[PPM_DEV_SPECIFIC_INIT_FLAG_BIT] = dev_specific_init_flag_q;
    cap_word[PPM_PMESUP_LSB+4:PPM_PMESUP_LSB] = pmesup_q;
    csr_word = '0;
    csr_word[PPM_POWER_STATE_FIELD_LSB+1:PPM_POWER_STATE_FIELD_LSB] = power_state_field_q;
    csr_word[PPM_KEEP_BIT] = keep_q;
    csr_word[PPM_WEN_BIT] = wen_q;
    csr_word[PPM_WST_BIT] = wst_q & ~UPSTREAM;
  end
  wire logic [31:0] rmux =
    sel_cap ? cap_word :
    sel_csr ? csr_word :
    sel_ist ? {29'h0, ist_q} :
    sel_imk ? {29'h0, imk_q} :
    sel_ctl ? {30'h0, d3cold_q, lock_q} : 32'h0;

  // APB answer one cycle into the access phase
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end
    else
    begin
      pready_o <= acc;
      pslverr_o <= acc & ~mapped;
      prdata_o <= rd ? rmux : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Wake message outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      wake_msg_o <= 1'b0;
      fwd_msg_o <= 1'b0;
      ctx_reset_o <= 1'b0;
      power_state_o <= PPM_POWER_STATE_FIELD_RST;
    end
    else
    begin
      wake_msg_o <= own_ev & wen_q & ~d3cold_q;
      fwd_msg_o <= fwd_wake_i & ~d3cold_q;
      ctx_reset_o <= ctx_rst;
      power_state_o <= power_state_field_q;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_own_ev;
    own_ev;
  endsequence
  a_wst_sets: assert property (@(posedge clock_i) disable iff (srst_i)
    s_own_ev |=> wst_q) else $error("wake status not set");
  a_wst_zero_clear: assert property (@(posedge clock_i) disable iff (srst_i)
    wst_q && cw.wr && !cw.wdata[PPM_WST_BIT] |=> wst_q)
    else $error("zero write cleared status");
  a_fwd_no_status: assert property (@(posedge clock_i) disable iff (srst_i)
    !wst_q && !own_wake_i && fwd_wake_i |=> !wst_q)
    else $error("forwarding set status");
  a_wake_gated: assert property (@(posedge clock_i) disable iff (srst_i)
    wake_msg_o |-> $past(wen_q) && !$past(d3cold_q))
    else $error("wake sent while disabled");
  a_d3cold_block: assert property (@(posedge clock_i) disable iff (srst_i)
    d3cold_q |=> !fwd_msg_o && !wake_msg_o)
    else $error("message in d3cold");
  a_hot_keeps_en: assert property (@(posedge clock_i) disable iff (srst_i)
    hot_rst_i && !cw.wr |=> wen_q == $past(wen_q))
    else $error("hot reset changed enable");
  a_power_state_field_legal: assert property (@(posedge clock_i) disable iff (srst_i)
    power_state_field_q != 2'h1 && power_state_field_q != 2'h2) else $error("reserved power state");
  a_ctx_reset: assert property (@(posedge clock_i) disable iff (srst_i)
    ctx_rst |=> power_state_field_q == PPM_D0 && keep_q && ctx_reset_o)
    else $error("context reset failed");
  a_lock_cap: assert property (@(posedge clock_i) disable iff (srst_i | hot_rst_i)
    lock_q && !hot_rst_i |=> $stable(pmesup_q) && $stable(dev_specific_init_flag_q))
    else $error("locked field changed");
  a_rsvd_zero: assert property (@(posedge clock_i) disable iff (srst_i)
    csr_word[31:16] == 16'h0 && cap_word[26:22] == 5'h0)
    else $error("reserved bits not zero");
  a_up_status: assert property (@(posedge clock_i) disable iff (srst_i)
    UPSTREAM |-> !csr_word[PPM_WST_BIT]) else $error("upstream status set");

  // ------------------------------------------------------------
  // Reset and sticky checks
  // ------------------------------------------------------------
  // Full reset restores the capability fields
  a_cap_defaults: assert property (@(posedge clock_i)
    srst_i |=> pmesup_q == PPM_PMESUP_RST && dev_specific_init_flag_q == PPM_DEV_SPECIFIC_INIT_FLAG_RST)
    else $error("capability defaults wrong");
  // Full reset restores power state and keep flag
  a_csr_defaults: assert property (@(posedge clock_i)
    srst_i |=> power_state_field_q == PPM_POWER_STATE_FIELD_RST && keep_q == PPM_KEEP_RST)
    else $error("control defaults wrong");
  // Full reset clears the sticky wake bits
  a_sticky_defaults: assert property (@(posedge clock_i)
    srst_i |=> wen_q == PPM_WEN_RST && !wst_q)
    else $error("sticky defaults wrong");
  // Hot reset alone leaves wake status where it was
  a_hot_keeps_st: assert property (@(posedge clock_i) disable iff (srst_i)
    hot_rst_i && !wst_set && !wst_clr |=> wst_q == $past(wst_q))
    else $error("hot reset changed status");
  // Hot reset restores the support field and the keep flag
  a_hot_cap_dflt: assert property (@(posedge clock_i) disable iff (srst_i)
    hot_rst_i |=> pmesup_q == PPM_PMESUP_RST && keep_q)
    else $error("hot reset missed defaults");

  // ------------------------------------------------------------
  // Wake and power state checks
  // ------------------------------------------------------------
  sequence s_keep_exit;
    wake_to_d0 && keep_q && !hot_rst_i;
  endsequence
  // A write of one clears status unless a new event lands
  a_status_w1c: assert property (@(posedge clock_i) disable iff (srst_i)
    wst_clr && !wst_set |=> !wst_q)
    else $error("status not cleared");
  // Own events set status whatever the written support field holds
  a_gen_fixed: assert property (@(posedge clock_i) disable iff (srst_i)
    !UPSTREAM && own_wake_i |=> wst_q)
    else $error("support field gated wake");
  // A refused power state write leaves the field alone
  a_bad_ps_kept: assert property (@(posedge clock_i) disable iff (srst_i)
    ps_bad && !hot_rst_i |=> $stable(power_state_field_q))
    else $error("reserved state taken");
  // With the keep flag set the move to D0 keeps context
  a_keep_context: assert property (@(posedge clock_i) disable iff (srst_i)
    s_keep_exit |=> power_state_field_q == PPM_D0 && !ctx_reset_o)
    else $error("context lost with keep set");
  // The context pulse follows only a real context reset
  a_ctx_pulse: assert property (@(posedge clock_i) disable iff (srst_i)
    ctx_reset_o |-> $past(ctx_rst))
    else $error("spurious context pulse");
  // Reserved and absent data fields stay zero
  a_rsvd_low: assert property (@(posedge clock_i) disable iff (srst_i)
    csr_word[14:9] == 6'h00 && csr_word[7:4] == 4'h0 && !csr_word[2] && cap_word[20:0] == 21'h0)
    else $error("reserved low bits set");
  // A wake message needs an own event
  a_wake_needs_ev: assert property (@(posedge clock_i) disable iff (srst_i)
    wake_msg_o |-> $past(own_ev))
    else $error("wake without event");
  // Unlocked capability writes land
  a_unlock_cap_wr: assert property (@(posedge clock_i) disable iff (srst_i | hot_rst_i)
    cap_wr |=> pmesup_q == $past(pwdata_i[PPM_PMESUP_LSB+4:PPM_PMESUP_LSB]))
    else $error("capability write lost");
  // Forwarding passes outside D3cold
  a_fwd_pass: assert property (@(posedge clock_i) disable iff (srst_i)
    fwd_wake_i && !d3cold_q |=> fwd_msg_o)
    else $error("forward dropped");
  // The upstream port never sends its own wake
  a_up_no_wake: assert property (@(posedge clock_i) disable iff (srst_i)
    UPSTREAM |-> !wake_msg_o)
    else $error("upstream wake sent");
  // Power state output mirrors the register one cycle later
  a_ps_out: assert property (@(posedge clock_i) disable iff (srst_i)
    1'b1 |=> power_state_o == $past(power_state_field_q))
    else $error("power state output lags wrong");

  // ------------------------------------------------------------
  // Bus and interrupt checks
  // ------------------------------------------------------------
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  // Every access phase gets its answer on the next edge
  a_ready_once: assert property (@(posedge clock_i) disable iff (srst_i)
    s_access |=> pready_o)
    else $error("no ready after access");
  // Ready is a single-cycle pulse
  a_ready_pulse: assert property (@(posedge clock_i) disable iff (srst_i)
    pready_o |=> !pready_o)
    else $error("ready held too long");
  // Error only travels with ready
  a_slverr_ready: assert property (@(posedge clock_i) disable iff (srst_i)
    pslverr_o |-> pready_o)
    else $error("error without ready");
  // A read of status clears it when no event lands
  a_status_read_clr: assert property (@(posedge clock_i) disable iff (srst_i)
    ist_rd && !(|ev) |=> ist_q == '0)
    else $error("status read did not clear");
  // Interrupt follows unmasked status one cycle later
  a_irq_level: assert property (@(posedge clock_i) disable iff (srst_i)
    1'b1 |=> irq_o == $past(|(ist_q & imk_q)))
    else $error("interrupt level wrong");
endmodule

/* logic/ppm_pkg.sv */
// Package for the port power management register block
package ppm_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] PPM_CAP_OFFS = 12'h0C0;
  localparam logic [11:0] PPM_CSR_OFFS = 12'h0C4;
  localparam logic [11:0] PPM_IRQ_STAT_OFFS = 12'h0C8;
  localparam logic [11:0] PPM_IRQ_MASK_OFFS = 12'h0CC;
  localparam logic [11:0] PPM_CTRL_OFFS = 12'h0D0;
  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int PPM_DEV_SPECIFIC_INIT_FLAG_BIT = 21;
  localparam int PPM_PMESUP_LSB = 27;
  localparam int PPM_POWER_STATE_FIELD_LSB = 0;
  localparam int PPM_KEEP_BIT = 3;
  localparam int PPM_WEN_BIT = 8;
  localparam int PPM_WST_BIT = 15;
  localparam logic PPM_DEV_SPECIFIC_INIT_FLAG_RST = 1'h0;
  localparam logic [4:0] PPM_PMESUP_RST = 5'h19;
  localparam logic [1:0] PPM_POWER_STATE_FIELD_RST = 2'h0;
  localparam logic PPM_KEEP_RST = 1'h1;
  localparam logic PPM_WEN_RST = 1'h0;
  localparam logic [1:0] PPM_D0 = 2'h0;
  localparam logic [1:0] PPM_D3HOT = 2'h3;
  // Interrupt status bits
  localparam int PPM_IRQ_WAKE = 0;
  localparam int PPM_IRQ_CTX = 1;
  localparam int PPM_IRQ_BAD = 2;
  localparam int PPM_IRQ_W = 3;
  // Control register bits
  localparam int PPM_CTRL_LOCK_BIT = 0;
  localparam int PPM_CTRL_D3C_BIT = 1;
  // Control/status register write request travelling from bus to logic
  typedef struct packed {
    logic wr;
    logic [31:0] wdata;
  } ppm_wr_t;
endpackage

/* tb/port_power_mgmt_cap_regs_test.sv */
// Self-checking testbench for the port power management register block
`timescale 1ns/1ps
module port_power_mgmt_cap_regs_test;
  import ppm_pkg::*;
  logic clock_i = 0, srst_i = 1, hot_rst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic own_wake_i = 0, fwd_wake_i = 0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, wake_msg_o, fwd_msg_o, ctx_reset_o, irq_o, err_seen;
  logic [1:0] power_state_o;
  logic [31:0] prdata_up, up_rd;
  int num_errors = 0, n_compared = 0, n_wake = 0, n_fwd = 0, n_ctx = 0;
  ppm_regs #(.UPSTREAM(1'b0)) uut (.clock_i(clock_i), .srst_i(srst_i), .hot_rst_i(hot_rst_i),
    .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .own_wake_i(own_wake_i), .fwd_wake_i(fwd_wake_i), .wake_msg_o(wake_msg_o),
    .fwd_msg_o(fwd_msg_o), .ctx_reset_o(ctx_reset_o), .power_state_o(power_state_o),
    .irq_o(irq_o));
  ppm_regs #(.UPSTREAM(1'b1)) uut_up (.clock_i(clock_i), .srst_i(srst_i),
    .hot_rst_i(hot_rst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_up), .pready_o(),
    .pslverr_o(), .own_wake_i(own_wake_i), .fwd_wake_i(fwd_wake_i), .wake_msg_o(),
    .fwd_msg_o(), .ctx_reset_o(), .power_state_o(), .irq_o());
  // ----------------------------------------
  // Clock, event counters and watchdog
  // ----------------------------------------
  initial
  begin
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    n_wake <= n_wake + (wake_msg_o === 1'b1);
    n_fwd <= n_fwd + (fwd_msg_o === 1'b1);
    n_ctx <= n_ctx + (ctx_reset_o === 1'b1);
  end
  initial
  begin
    #(25 * 5000);
    num_errors++;
    close_out();
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; waits for pready, then releases and idles a cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    psel_i <= 1'b1;
    paddr_i <= a;
    pwrite_i <= wr;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h0, 32'h1);
    rd = prdata_o;
    up_rd = prdata_up;
    err_seen = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(name, r, exp);
  endtask
  // One-cycle event on the wake inputs, then time for the outputs to settle
  task automatic pulse(input logic own, input logic fwd);
    own_wake_i <= own;
    fwd_wake_i <= fwd;
    @(posedge clock_i);
    own_wake_i <= 1'b0;
    fwd_wake_i <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_caps();
    rd("cap reset", PPM_CAP_OFFS, 32'hC8000000);
    rd("csr reset", PPM_CSR_OFFS, 32'h00000008);
    wr(PPM_CAP_OFFS, 32'hFFFFFFFF);
    rd("cap ones", PPM_CAP_OFFS, 32'hF8200000);
    wr(PPM_CTRL_OFFS, 32'h00000001);
    wr(PPM_CAP_OFFS, 32'h00000000);
    wr(PPM_CSR_OFFS, 32'h00000000);
    rd("cap locked", PPM_CAP_OFFS, 32'hF8200000);
    rd("keep locked", PPM_CSR_OFFS, 32'h00000008);
    wr(PPM_CTRL_OFFS, 32'h00000000);
    rd("unmapped", 12'h0D4, 32'h00000000);
    chk("slverr", {31'h0, err_seen}, 32'h1);
    $display("test caps done");
  endtask
  task automatic t_csr();
    wr(PPM_IRQ_MASK_OFFS, 32'h00000007);
    wr(PPM_CSR_OFFS, 32'hFFFFFFFF);
    rd("csr ones", PPM_CSR_OFFS, 32'h0000010B);
    chk("power_state_field out", {30'h0, power_state_o}, 32'h3);
    wr(PPM_CSR_OFFS, 32'h00000109);
    rd("csr bad power_state_field", PPM_CSR_OFFS, 32'h0000010B);
    chk("irq high", {31'h0, irq_o}, 32'h1);
    rd("irq stat bad", PPM_IRQ_STAT_OFFS, 32'h00000004);
    rd("irq stat clr", PPM_IRQ_STAT_OFFS, 32'h00000000);
    chk("irq low", {31'h0, irq_o}, 32'h0);
    $display("test csr done");
  endtask
  task automatic t_wake();
    wr(PPM_CAP_OFFS, 32'h00000000);
    pulse(1'b1, 1'b0);
    chk("wake msg", n_wake, 1);
    rd("status set", PPM_CSR_OFFS, 32'h0000810B);
    chk("up status", {31'h0, up_rd[15]}, 32'h0);
    rd("irq stat wake", PPM_IRQ_STAT_OFFS, 32'h00000001);
    wr(PPM_CSR_OFFS, 32'h0000010B);
    rd("status w0", PPM_CSR_OFFS, 32'h0000810B);
    wr(PPM_CSR_OFFS, 32'h00008003);
    rd("status w1c", PPM_CSR_OFFS, 32'h00000003);
    pulse(1'b1, 1'b0);
    chk("wake gated", n_wake, 1);
    rd("status no en", PPM_CSR_OFFS, 32'h00008003);
    wr(PPM_CSR_OFFS, 32'h00008103);
    wr(PPM_CTRL_OFFS, 32'h00000002);
    pulse(1'b1, 1'b1);
    chk("cold wake", n_wake, 1);
    chk("cold fwd", n_fwd, 0);
    wr(PPM_CSR_OFFS, 32'h00008103);
    wr(PPM_CTRL_OFFS, 32'h00000000);
    pulse(1'b0, 1'b1);
    chk("fwd msg", n_fwd, 1);
    rd("fwd no status", PPM_CSR_OFFS, 32'h00000103);
    $display("test wake done");
  endtask
  task automatic t_resets();
    hot_rst_i <= 1'b1;
    @(posedge clock_i);
    hot_rst_i <= 1'b0;
    @(posedge clock_i);
    rd("hot csr", PPM_CSR_OFFS, 32'h00000108);
    rd("hot cap", PPM_CAP_OFFS, 32'hC8000000);
    wr(PPM_CSR_OFFS, 32'h00000103);
    wr(PPM_CSR_OFFS, 32'h00000100);
    chk("ctx pulse", n_ctx, 1);
    rd("ctx csr", PPM_CSR_OFFS, 32'h00000108);
    rd("irq stat ctx", PPM_IRQ_STAT_OFFS, 32'h00000003);
    srst_i <= 1'b1;
    @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    rd("full csr", PPM_CSR_OFFS, 32'h00000008);
    $display("test resets done");
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    t_caps();
    t_csr();
    t_wake();
    t_resets();
    close_out();
  end
endmodule
